// File: sim/spe_host_model.sv
`timescale 1ns/1ps
module spe_host_model
   import spe_pkg::*;
(
   // clock and request
   input wire logic mclk,
   input wire logic go,
   // sensor pins
   input wire logic echo,
   output logic trigger,
   // timing result
   output logic done,
   output int rise_cnt,
   output int fall_cnt,
   output int dist_cm,
   output int dist_in
);
   int k;
   // half the round trip, whole units only
   function automatic int to_dist(input int width_cyc, input int unsigned us_per_unit);
      return width_cyc / (2 * int'(CLK_HZ / 1_000_000) * int'(us_per_unit));
   endfunction
   initial
   begin
      trigger = 1'b0;
      done = 1'b0;
      forever
      begin
         @(posedge mclk);
         if (go)
         begin
            done <= 1'b0;
            trigger <= 1'b1;
            repeat (TRIG_MIN_CYC) @(posedge mclk);
            trigger <= 1'b0;
            rise_cnt = 0;
            k = 0;
            // already watching before the rise can come
            while (k < 30000 && (rise_cnt == 0 || echo === 1'b1))
            begin
               @(negedge mclk);
               k++;
               if (echo === 1'b1 && rise_cnt == 0)
                  rise_cnt = k;
            end
            fall_cnt = k;
            dist_cm = to_dist(fall_cnt - rise_cnt, US_PER_CM);
            dist_in = to_dist(fall_cnt - rise_cnt, US_PER_INCH);
            done = 1'b1;
         end
      end
   end
endmodule

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
   import spe_pkg::*;
   localparam int BL = 50;
   localparam int TO = 20000;
   logic mclk, rst_n, trigger, echo, reflect_det, burst_out, go, done;
   int rise_cnt, fall_cnt, dist_cm, dist_in, n_mismatch, cmp_count, cyc;
   logic [7:0] seed;
   spe_sonar #(.TIMEOUT_CYCLES(TO), .BLANK_CYCLES(BL)) i_spe_sonar (.mclk(mclk),
      .rst_n(rst_n), .trigger(trigger), .echo(echo), .reflect_det(reflect_det),
      .burst_out(burst_out));
   spe_host_model i_spe_host_model (.mclk(mclk), .go(go), .echo(echo),
      .trigger(trigger), .done(done), .rise_cnt(rise_cnt), .fall_cnt(fall_cnt),
      .dist_cm(dist_cm), .dist_in(dist_in));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // whole microseconds, halved for one way, then per unit
   function automatic int exp_dist(input int width_cyc, input int unsigned us_per_unit);
      int us;
      us = width_cyc / int'(CLK_HZ / 1_000_000);
      return (us / 2) / int'(us_per_unit);
   endfunction
   task automatic chk_int(input string n, input int e, input int g);
      cmp_count++;
      if (e != g)
      begin
         n_mismatch++;
         $display("[FAIL] %s exp %0d got %0d", n, e, g);
      end
   endtask
   task automatic chk_bit(input string n, input logic e, input logic g);
      cmp_count++;
      if (e !== g)
      begin
         n_mismatch++;
         $display("[FAIL] %s exp %b got %b", n, e, g);
      end
   endtask
   task automatic tally_and_finish();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // dly 0 means no reflection, so the run ends by timeout
   task automatic ping(input int dly, input logic noise);
      int k;
      int w;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      repeat (500) @(posedge mclk);
      chk_bit("burst_on_rise", 1'b0, burst_out);
      while (trigger === 1'b1) @(posedge mclk);
      if (noise)
      begin
         repeat (BL / 2)
         begin
            @(posedge mclk);
            seed = lfsr(seed);
            reflect_det <= seed[0];
         end
         @(posedge mclk);
         reflect_det <= 1'b0;
      end
      while (echo !== 1'b1 && k < 5000)
      begin
         @(negedge mclk);
         k++;
      end
      if (dly > 0)
      begin
         repeat (dly) @(posedge mclk);
         reflect_det <= 1'b1;
         @(posedge mclk);
         reflect_det <= 1'b0;
      end
      else
      begin
         // low phase only: the high phase was entered before we looked
         while (burst_out === 1'b1) @(posedge mclk);
         k = 0;
         while (burst_out === 1'b0 && k < 3000)
         begin
            @(posedge mclk);
            k++;
         end
         chk_int("half_carrier", int'(HALF_CARRIER_CYC), k);
      end
      while (done !== 1'b1) @(posedge mclk);
      chk_int("echo_rise", BL + 2, rise_cnt);
      if (dly > 0)
         chk_int("echo_fall", BL + 3 + dly, fall_cnt);
      else
         chk_int("echo_timeout", TO + 2, fall_cnt);
      chk_bit("echo_low", 1'b0, echo);
      // echo width in cycles: reflection lands dly + 1 after the rise
      w = (dly > 0) ? dly + 1 : TO - BL;
      chk_int("dist_cm", exp_dist(w, US_PER_CM), dist_cm);
      chk_int("dist_in", exp_dist(w, US_PER_INCH), dist_in);
      // burst outlives a short echo; let it finish before the next ping
      k = int'(BURST_CYCLES * 2 * HALF_CARRIER_CYC) + 100 - fall_cnt;
      repeat (k) @(posedge mclk);
   endtask
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   initial
   begin
      {rst_n, go, reflect_det} = 3'h0;
      {seed, n_mismatch, cmp_count, cyc} = {8'h38, 96'h0};
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      seed = lfsr(seed);
      ping(int'(seed[6:0]) * 128 + 1, 1'b0);
      ping(1, 1'b1);
      ping(0, 1'b0);
      tally_and_finish();
   end
endmodule

// File: verilog/spe_pkg.sv
package spe_pkg;
   // clock rate and documented times
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned TRIG_MIN_US = 10;
   localparam int unsigned BLANK_US = 100;
   localparam int unsigned TIMEOUT_MS = 36;
   localparam int unsigned BURST_KHZ = 40;
   // derived cycle counts
   localparam int unsigned TRIG_MIN_CYC = TRIG_MIN_US * (CLK_HZ / 1_000_000);
   localparam int unsigned BLANK_CYC = BLANK_US * (CLK_HZ / 1_000_000);
   localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1_000);
   localparam int unsigned HALF_CARRIER_CYC = CLK_HZ / (BURST_KHZ * 1_000 * 2);
   // burst length in carrier cycles
   localparam int unsigned BURST_CYCLES = 8;
   // microseconds of one-way flight per unit of range
   localparam int unsigned US_PER_INCH = 74;
   localparam int unsigned US_PER_CM = 29;
   localparam int CNT_W = 24;
   localparam int HALF_W = 12;
   localparam int BURST_W = 4;
   typedef enum logic [1:0] {SPE_IDLE, SPE_BLANK, SPE_LISTEN} spe_state_t;
endpackage

// File: verilog/spe_sonar.sv
// How it works
// R1 - host holds trigger low, then high at least 10 us to request a ping
// R2 - burst starts on the trigger falling edge, never on its rise
// R3 - receiver blanked 100 us after burst start before listening
// R4 - echo output low until blanking ends, then driven high
// R5 - while listening, echo drops on reflection or timeout, whichever first
// R6 - with no reflection, echo ends about 36 ms after measurement start
// R7 - host times from echo rise to echo fall for distance
// R8 - echo is a positive pulse, width proportional to distance
// R9 - host halves round trip, divides us by 74 inches or 29 cm
// R10 - host must already watch for the echo rise when it comes
// R11 - burst carrier runs at 40 kHz
// R12 - host waits for echo low before a new ping request
`timescale 1ns/1ps
module spe_sonar
   import spe_pkg::*;
#(
   // timeout counts from burst start, so it must stay above blanking
   parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
   parameter int unsigned BLANK_CYCLES = BLANK_CYC
)
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // host pins
   input wire logic trigger,
   output logic echo,
   // transducer side
   input wire logic reflect_det,
   output logic burst_out
);

   spe_state_t state_reg;
   logic trig_d_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [HALF_W-1:0] half_reg;
   logic [BURST_W-1:0] nburst_reg;
   logic burst_on_reg;
   logic trig_fall;

   // >= so a count pushed past its limit still ends the phase
   function automatic logic at_end(input logic [CNT_W-1:0] c, input int unsigned lim);
      at_end = (c >= CNT_W'(lim - 1));
   endfunction

   // edge detect; a fall while busy is ignored so one measurement runs
   assign trig_fall = trig_d_reg & ~trigger; // R2

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         trig_d_reg <= 1'b0;
      else
         trig_d_reg <= trigger;
   end

   // measurement sequence; one counter spans blanking and timeout
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         state_reg <= SPE_IDLE;
         cnt_reg <= '0;
      end
      else
      begin
         case (state_reg)
            SPE_IDLE:
            begin
               cnt_reg <= '0;
               if (trig_fall) // R2
                  state_reg <= SPE_BLANK;
            end
            SPE_BLANK:
            begin
               cnt_reg <= cnt_reg + 1'b1;
               if (at_end(cnt_reg, BLANK_CYCLES)) // R3
                  state_reg <= SPE_LISTEN;
            end
            SPE_LISTEN:
            begin
               cnt_reg <= cnt_reg + 1'b1;
               if (reflect_det || at_end(cnt_reg, TIMEOUT_CYCLES)) // R5 R6
                  state_reg <= SPE_IDLE;
            end
            default:
               state_reg <= SPE_IDLE;
         endcase
      end
   end

   // echo high exactly while listening: width tracks range
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         echo <= 1'b0;
      else if (state_reg == SPE_BLANK && at_end(cnt_reg, BLANK_CYCLES))
         echo <= 1'b1; // R4 R8
      else if (state_reg == SPE_LISTEN &&
               (reflect_det || at_end(cnt_reg, TIMEOUT_CYCLES)))
         echo <= 1'b0; // R5 R6
      else if (state_reg == SPE_IDLE)
         echo <= 1'b0; // R4
   end

   // 40 kHz carrier, fixed count of cycles from the trigger fall
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         burst_on_reg <= 1'b0;
         burst_out <= 1'b0;
         half_reg <= '0;
         nburst_reg <= '0;
      end
      else if (state_reg == SPE_IDLE && trig_fall)
      begin
         burst_on_reg <= 1'b1; // R2
         burst_out <= 1'b1;
         half_reg <= '0;
         nburst_reg <= '0;
      end
      else if (burst_on_reg)
      begin
         if (half_reg == HALF_W'(HALF_CARRIER_CYC - 1))
         begin
            half_reg <= '0;
            burst_out <= ~burst_out; // R11
            if (burst_out == 1'b0 && nburst_reg == BURST_W'(BURST_CYCLES - 1))
            begin
               burst_on_reg <= 1'b0;
               burst_out <= 1'b0;
            end
            else if (burst_out == 1'b0)
               nburst_reg <= nburst_reg + 1'b1;
         end
         else
            half_reg <= half_reg + 1'b1;
      end
   end

   // checks
   sequence s_start;
      state_reg == SPE_IDLE && trig_fall;
   endsequence

   sequence s_blank_quiet;
      !echo [*8];
   endsequence

   a_start_on_fall: assert property (@(posedge mclk) disable iff (!rst_n) // R2
      s_start |=> state_reg == SPE_BLANK && burst_out)
      else $error("burst did not start on trigger fall");

   a_no_start_rise: assert property (@(posedge mclk) disable iff (!rst_n) // R2
      (state_reg == SPE_IDLE && trigger && !trig_d_reg) |=> state_reg == SPE_IDLE)
      else $error("measurement started on trigger rise");

   a_echo_low_blank: assert property (@(posedge mclk) disable iff (!rst_n) // R4
      s_start |=> s_blank_quiet)
      else $error("echo rose during blanking");

   a_blank_length: assert property (@(posedge mclk) disable iff (!rst_n) // R3
      (state_reg == SPE_BLANK && cnt_reg < CNT_W'(BLANK_CYCLES - 1)) |=> !echo)
      else $error("blanking ended early");

   a_echo_rise: assert property (@(posedge mclk) disable iff (!rst_n) // R4
      (state_reg == SPE_BLANK && at_end(cnt_reg, BLANK_CYCLES)) |=> echo)
      else $error("echo not raised after blanking");

   a_reflect_fall: assert property (@(posedge mclk) disable iff (!rst_n) // R5
      (state_reg == SPE_LISTEN && reflect_det) |=> !echo && state_reg == SPE_IDLE)
      else $error("echo not dropped on reflection");

   a_timeout_fall: assert property (@(posedge mclk) disable iff (!rst_n) // R6
      (state_reg == SPE_LISTEN && at_end(cnt_reg, TIMEOUT_CYCLES)) |=> !echo)
      else $error("echo not dropped at timeout");

   a_echo_listen: assert property (@(posedge mclk) disable iff (!rst_n) // R8
      echo |-> state_reg == SPE_LISTEN)
      else $error("echo high outside listening");

   a_carrier_half: assert property (@(posedge mclk) disable iff (!rst_n) // R11
      (burst_on_reg && $rose(burst_out) && !$past(trig_fall))
      |-> $past(burst_out, 1) == 1'b0 && $past(half_reg) == HALF_W'(HALF_CARRIER_CYC - 1))
      else $error("carrier half period wrong");

   // burst and phase bookkeeping
   sequence s_burst_last;
      burst_on_reg && !burst_out && nburst_reg == BURST_W'(BURST_CYCLES - 1)
         && half_reg == HALF_W'(HALF_CARRIER_CYC - 1)
         && !(state_reg == SPE_IDLE && trig_fall);
   endsequence

   a_burst_stop: assert property (@(posedge mclk) disable iff (!rst_n) // R11
      s_burst_last |=> !burst_on_reg && !burst_out)
      else $error("burst did not stop after its last period");

   a_burst_on_fall: assert property (@(posedge mclk) disable iff (!rst_n) // R2
      $rose(burst_on_reg) |-> $past(state_reg == SPE_IDLE && trig_fall))
      else $error("burst started without a trigger fall");

   a_carrier_low: assert property (@(posedge mclk) disable iff (!rst_n) // R11
      (burst_on_reg && $fell(burst_out))
      |-> $past(half_reg) == HALF_W'(HALF_CARRIER_CYC - 1))
      else $error("carrier high phase wrong");

   a_blank_deaf: assert property (@(posedge mclk) disable iff (!rst_n) // R3
      (state_reg == SPE_BLANK && reflect_det && !at_end(cnt_reg, BLANK_CYCLES))
      |=> state_reg == SPE_BLANK && !echo)
      else $error("reflection heeded during blanking");

   a_listen_bound: assert property (@(posedge mclk) disable iff (!rst_n) // R6
      state_reg == SPE_LISTEN |-> cnt_reg <= CNT_W'(TIMEOUT_CYCLES - 1))
      else $error("listening outlived the timeout");

   a_echo_fall_cause: assert property (@(posedge mclk) disable iff (!rst_n) // R5
      $fell(echo) |-> $past(state_reg == SPE_LISTEN &&
         (reflect_det || at_end(cnt_reg, TIMEOUT_CYCLES))))
      else $error("echo dropped without reflection or timeout");

   a_reset_quiet: assert property (@(posedge mclk) // R4
      !rst_n |=> !echo && !burst_out && state_reg == SPE_IDLE)
      else $error("outputs not quiet after reset");

endmodule
